// ===== bmp_buffer_manager.sv
/*
  Buffer manager pointers: host and disk pointer registers and their
  address counters, the 12-bit host transfer counter, arm latches,
  buffer control and status, and the microcontroller RAM port through
  a 32-byte disk FIFO. Assumes every input comes from logic on the
  same clock: the microcontroller bus decoder gives one-cycle read and
  write strobes, the host and drive engines give byte strobes, and the
  auxiliary register bits arrive as levels.
*/
`timescale 1ns/1ns

module bmp_buffer_manager (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  mcAddr,
  input  wire logic        mcWrite,
  input  wire logic        mcRead,
  input  wire logic [7:0]  mcWrData,
  output logic      [7:0]  mcRdData_q,
  output logic             ramPortFull_q,
  input  wire logic        hostDmaSelect,
  input  wire logic        hostSlaveSelect,
  input  wire logic        microRamAccessEnable,
  input  wire logic        hostByteStrobe,
  input  wire logic        driveBufferRequest,
  input  wire logic        driveByteStrobe,
  input  wire logic        drqFlagClear,
  output logic [14:0]      hostAddr_q,
  output logic [11:0]      xferCnt_q,
  output logic [14:0]      diskAddr_q,
  output logic             hostDirection_q,
  output logic             diskDirection_q,
  output logic             clearTransferCounter_q,
  output logic             hostAtMode_q,
  output logic             hostSlaveMode_q,
  output logic             hostDmaMode_q,
  output logic             burstDmaActive_q,
  output logic             driveBufferRequestFlag_q,
  output logic             driveHalt_q,
  output logic             bufAddrOe_q,
  output logic [14:0]      ramAddr_q,
  output logic             ramWrEn_q,
  output logic [7:0]       ramWrData_q,
  input  wire logic        ramWrReady,
  output logic             ramRdReq_q,
  input  wire logic        ramRdValid,
  input  wire logic [7:0]  ramRdData
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [14:0] hostPtr_q;
  logic [11:0] hostCnt_q;
  logic [14:0] diskPtr_q;
  logic        busStyle_q = 1'b0;
  logic        hostArm_q;
  logic        burstEnable_q;
  logic        diskArm_q;
  logic        bdrqPrev_q;
  logic        rdPending_q;

  // Steps a buffer address by one; the sum wraps inside fifteen bits.
  function automatic logic [14:0] nextAddr(input logic [14:0] addr);
    nextAddr = addr + 15'h0001;
  endfunction : nextAddr

  // ----------------------------------------------------------------------
  // Address decode of the microcontroller port.
  // ----------------------------------------------------------------------
  wire logic wrHostPtrLo = mcWrite && (mcAddr == bmp_pkg::ADDR_HOST_PTR_LO);
  wire logic wrHostPtrHi = mcWrite && (mcAddr == bmp_pkg::ADDR_HOST_PTR_HI);
  wire logic wrHostCntLo = mcWrite && (mcAddr == bmp_pkg::ADDR_HOST_CNT_LO);
  wire logic wrHostCntHi = mcWrite && (mcAddr == bmp_pkg::ADDR_HOST_CNT_HI);
  wire logic wrDiskPtrLo = mcWrite && (mcAddr == bmp_pkg::ADDR_DISK_PTR_LO);
  wire logic wrDiskPtrHi = mcWrite && (mcAddr == bmp_pkg::ADDR_DISK_PTR_HI);
  wire logic wrRamPort   = mcWrite && (mcAddr == bmp_pkg::ADDR_RAM_PORT);
  wire logic wrCtrl      = mcWrite && (mcAddr == bmp_pkg::ADDR_BUF_CTRL);
  wire logic rdRamPort   = mcRead && (mcAddr == bmp_pkg::ADDR_RAM_PORT);

  // Status mirrors each control bit or latch in its own position.
  wire logic [7:0] statusByte = {busStyle_q, !bufAddrOe_q, clearTransferCounter_q, hostArm_q,
                                 hostDirection_q, diskDirection_q, burstEnable_q, diskArm_q};

  // ----------------------------------------------------------------------
  // Host side: arm, load and count.
  // ----------------------------------------------------------------------
  wire logic hostArmWrite = wrCtrl && mcWrData[bmp_pkg::BIT_HOST_ARM];
  wire logic cntZero      = (xferCnt_q == '0);
  wire logic hostLoad     = hostArm_q && cntZero && !clearTransferCounter_q;
  wire logic hostMove     = hostByteStrobe && !cntZero && !clearTransferCounter_q;

  wire logic [14:0] hostAddr_d = hostLoad ? hostPtr_q :
                                 hostMove ? nextAddr(hostAddr_q) : hostAddr_q;
  wire logic [11:0] xferCnt_d  = clearTransferCounter_q ? 12'h000 :
                                 hostLoad ? hostCnt_q :
                                 hostMove ? xferCnt_q - 12'h001 : xferCnt_q;
  // A new arm written in the load cycle wins over the clear.
  wire logic hostArm_d = hostArmWrite ? 1'b1 : (hostLoad ? 1'b0 : hostArm_q);

  // ----------------------------------------------------------------------
  // Disk side: request edge, arm, halt and load.
  // ----------------------------------------------------------------------
  wire logic bdrqRise     = driveBufferRequest && !bdrqPrev_q;
  wire logic diskArmWrite = wrCtrl && mcWrData[bmp_pkg::BIT_DISK_ARM];
  wire logic microArm     = diskArmWrite && microRamAccessEnable;
  wire logic diskLoad     = (diskArm_q && (bdrqRise || driveHalt_q)) || microArm;
  wire logic diskArm_d    = (diskArmWrite && !microRamAccessEnable) ? 1'b1 :
                            (diskLoad ? 1'b0 : diskArm_q);
  wire logic driveHalt_d  = (bdrqRise && !diskArm_q) ? 1'b1 :
                            (diskArm_q ? 1'b0 : driveHalt_q);
  // Set beats clear; a pending halt also holds the flag until arming.
  wire logic drqFlag_d    = bdrqRise ? 1'b1 :
                            ((drqFlagClear && !driveHalt_q) ? 1'b0 : driveBufferRequestFlag_q);

  // ----------------------------------------------------------------------
  // Microcontroller RAM port through the disk FIFO.
  // ----------------------------------------------------------------------
  wire logic       fifoInReady;
  wire logic       fifoOutValid;
  wire logic [7:0] fifoOutData;
  wire logic       portEnabled = microRamAccessEnable;
  wire logic       fifoInValid = diskDirection_q ? ramRdValid : (wrRamPort && portEnabled);
  wire logic [7:0] fifoInData  = diskDirection_q ? ramRdData : mcWrData;
  wire logic       fifoOutRdy  = diskDirection_q ? (rdRamPort && portEnabled) : ramWrReady;
  wire logic       ramWrite    = !diskDirection_q && fifoOutValid && ramWrReady;
  wire logic       ramReadIssue = diskDirection_q && portEnabled && fifoInReady
                                  && !rdPending_q && !microArm;
  wire logic       diskMove    = (driveByteStrobe && !driveHalt_q) || ramWrite || ramReadIssue;
  wire logic [14:0] diskAddr_d = diskLoad ? diskPtr_q :
                                 diskMove ? nextAddr(diskAddr_q) : diskAddr_q;

  bmp_fifo #(
    .WIDTH (bmp_pkg::FIFO_W),
    .DEPTH (bmp_pkg::FIFO_D)
  ) u_disk_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .flush    (microArm),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutRdy),
    .outData  (fifoOutData)
  );

  // Read data selection; unmapped addresses read as zero.
  wire logic [7:0] rdSel =
    (mcAddr == bmp_pkg::ADDR_HOST_PTR_LO) ? hostPtr_q[7:0] :
    (mcAddr == bmp_pkg::ADDR_HOST_PTR_HI) ? {1'b0, hostPtr_q[14:8]} :
    (mcAddr == bmp_pkg::ADDR_HOST_CNT_LO) ? hostCnt_q[7:0] :
    (mcAddr == bmp_pkg::ADDR_HOST_CNT_HI) ? {4'h0, hostCnt_q[11:8]} :
    (mcAddr == bmp_pkg::ADDR_DISK_PTR_LO) ? diskPtr_q[7:0] :
    (mcAddr == bmp_pkg::ADDR_DISK_PTR_HI) ? {1'b0, diskPtr_q[14:8]} :
    (mcAddr == bmp_pkg::ADDR_RAM_PORT)    ? ((fifoOutValid && portEnabled && diskDirection_q)
                                             ? fifoOutData : bmp_pkg::RD_UNMAPPED) :
    (mcAddr == bmp_pkg::ADDR_BUF_CTRL)    ? statusByte : bmp_pkg::RD_UNMAPPED;

  // ----------------------------------------------------------------------
  // Pointer and count registers written by the microcontroller.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hostPtr_q <= '0;
      hostCnt_q <= '0;
      diskPtr_q <= '0;
    end
    else
    begin
      if (wrHostPtrLo) hostPtr_q[7:0]  <= mcWrData;
      if (wrHostPtrHi) hostPtr_q[14:8] <= mcWrData[6:0];
      if (wrHostCntLo) hostCnt_q[7:0]  <= mcWrData;
      if (wrHostCntHi) hostCnt_q[11:8] <= mcWrData[3:0];
      if (wrDiskPtrLo) diskPtr_q[7:0]  <= mcWrData;
      if (wrDiskPtrHi) diskPtr_q[14:8] <= mcWrData[6:0];
    end
  end

  // Bus style bit keeps its value through reset.
  always_ff @(posedge clk)
  begin
    if (wrCtrl) busStyle_q <= mcWrData[bmp_pkg::BIT_BUS_STYLE];
  end

  // ----------------------------------------------------------------------
  // Buffer control bits and latches.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bufAddrOe_q            <= 1'b1;
      clearTransferCounter_q <= 1'b0;
      hostArm_q              <= 1'b0;
      hostDirection_q        <= 1'b0;
      diskDirection_q        <= 1'b0;
      burstEnable_q          <= 1'b0;
      diskArm_q              <= 1'b0;
    end
    else
    begin
      if (wrCtrl) bufAddrOe_q <= !mcWrData[bmp_pkg::BIT_CFG_READ];
      clearTransferCounter_q <= wrCtrl && mcWrData[bmp_pkg::BIT_CLR_CNT];
      if (wrCtrl) hostDirection_q <= mcWrData[bmp_pkg::BIT_HOST_DIR];
      if (wrCtrl) diskDirection_q <= mcWrData[bmp_pkg::BIT_DISK_DIR];
      if (wrCtrl) burstEnable_q   <= mcWrData[bmp_pkg::BIT_BURST];
      hostArm_q <= hostArm_d;
      diskArm_q <= diskArm_d;
    end
  end

  // ----------------------------------------------------------------------
  // Counters, disk request state and the RAM read pending flag.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hostAddr_q               <= '0;
      xferCnt_q                <= '0;
      diskAddr_q               <= '0;
      bdrqPrev_q               <= 1'b0;
      driveHalt_q              <= 1'b0;
      driveBufferRequestFlag_q <= 1'b0;
      rdPending_q              <= 1'b0;
    end
    else
    begin
      hostAddr_q               <= hostAddr_d;
      xferCnt_q                <= xferCnt_d;
      diskAddr_q               <= diskAddr_d;
      bdrqPrev_q               <= driveBufferRequest;
      driveHalt_q              <= driveHalt_d;
      driveBufferRequestFlag_q <= drqFlag_d;
      rdPending_q              <= ramReadIssue ? 1'b1 : (ramRdValid ? 1'b0 : rdPending_q);
    end
  end

  // RAM strobes and registered outputs.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ramAddr_q        <= '0;
      ramWrEn_q        <= 1'b0;
      ramWrData_q      <= '0;
      ramRdReq_q       <= 1'b0;
      mcRdData_q       <= '0;
      ramPortFull_q    <= 1'b0;
      hostAtMode_q     <= 1'b0;
      hostSlaveMode_q  <= 1'b0;
      hostDmaMode_q    <= 1'b0;
      burstDmaActive_q <= 1'b0;
    end
    else
    begin
      if (ramWrite || ramReadIssue) ramAddr_q <= diskAddr_q;
      ramWrEn_q        <= ramWrite;
      if (ramWrite) ramWrData_q <= fifoOutData;
      ramRdReq_q       <= ramReadIssue;
      if (mcRead) mcRdData_q <= rdSel;
      ramPortFull_q    <= !fifoInReady;
      hostAtMode_q     <= busStyle_q && !hostSlaveSelect;
      hostSlaveMode_q  <= hostSlaveSelect;
      hostDmaMode_q    <= hostDmaSelect;
      burstDmaActive_q <= burstEnable_q && hostDmaSelect;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_host_load: assert property (hostArm_q && cntZero && !clearTransferCounter_q
    |=> hostAddr_q == $past(hostPtr_q) && xferCnt_q == $past(hostCnt_q))
    else $error("Host pointer and count did not load.");
  a_host_arm_clr: assert property (hostLoad && !hostArmWrite |=> !hostArm_q)
    else $error("Host armed bit stayed set after load.");
  a_count_limit: assert property (cntZero && !hostLoad |=> hostAddr_q == $past(hostAddr_q))
    else $error("Host address moved with zero count.");
  a_clear_cnt: assert property (wrCtrl && mcWrData[bmp_pkg::BIT_CLR_CNT] |=> clearTransferCounter_q ##1
    (!clearTransferCounter_q || $past(wrCtrl)) && cntZero)
    else $error("Transfer counter clear misbehaved.");
  a_disk_load: assert property (diskArm_q && bdrqRise && !microArm
    |=> diskAddr_q == $past(diskPtr_q) && !driveHalt_q)
    else $error("Disk pointer did not load on request.");
  a_drive_halt: assert property (bdrqRise && !diskArm_q && !diskArmWrite
    |=> driveHalt_q && driveBufferRequestFlag_q [*2])
    else $error("Drive request without arm did not halt.");
  a_status_read: assert property (mcRead && mcAddr == bmp_pkg::ADDR_BUF_CTRL
    |=> mcRdData_q == $past(statusByte))
    else $error("Status read does not mirror control.");
  a_cfg_float: assert property (wrCtrl && mcWrData[bmp_pkg::BIT_CFG_READ] |=> !bufAddrOe_q)
    else $error("Config read mode did not float the address.");
  a_burst_gate: assert property (burstDmaActive_q |-> $past(burstEnable_q) && $past(hostDmaSelect))
    else $error("Burst DMA without both enables.");
  a_micro_flush: assert property (microArm |=> diskAddr_q == $past(diskPtr_q) && !fifoOutValid)
    else $error("Microcontroller arm did not reset the disk FIFO.");

  // A write of one sets a latch, the disk latch only without access enable; nothing in that cycle may clear it.
  a_host_arm_set: assert property (hostArmWrite |=> hostArm_q)
    else $error("Host arm write did not set the latch.");
  a_disk_arm_set: assert property (diskArmWrite && !microRamAccessEnable |=> diskArm_q)
    else $error("Disk arm write did not set the latch.");

  // Both direction bits follow every control write.
  a_dir_bits: assert property (wrCtrl
    |=> hostDirection_q == $past(mcWrData[bmp_pkg::BIT_HOST_DIR])
    && diskDirection_q == $past(mcWrData[bmp_pkg::BIT_DISK_DIR]))
    else $error("Direction bits did not follow the control write.");

  // Mode copies lag one cycle, so they are checked from the second cycle after reset.
  a_bus_style: assert property ($past(resetn)
    |-> hostAtMode_q == ($past(busStyle_q) && !$past(hostSlaveSelect)))
    else $error("Bus style output does not follow its bits.");
  a_dma_mode: assert property ($past(resetn) |-> hostDmaMode_q == $past(hostDmaSelect))
    else $error("Host DMA mode does not follow its select.");
  a_slave_mode: assert property ($past(resetn) |-> hostSlaveMode_q == $past(hostSlaveSelect))
    else $error("Host slave mode does not follow its select.");

  // RAM reads only start while the port is enabled.
  a_ram_gate: assert property (ramRdReq_q |-> $past(microRamAccessEnable))
    else $error("RAM read issued without access enable.");

  // A load beats a step, so load cycles are left out.
  a_disk_step: assert property (diskMove && !diskLoad
    |=> diskAddr_q == $past(diskAddr_q) + 15'h0001)
    else $error("Disk address did not step by one.");

  // A halted request keeps its flag, and reset leaves config read mode off.
  a_flag_hold: assert property (driveHalt_q |-> driveBufferRequestFlag_q)
    else $error("Request flag dropped while halted.");
  a_cfg_reset: assert property (!$past(resetn) |-> bufAddrOe_q)
    else $error("Config read mode survived reset.");

  c_host_queue: cover property (hostArm_q && hostMove ##[1:50] hostLoad);
  c_disk_halt: cover property (driveHalt_q ##[1:50] diskLoad);
  c_micro_write: cover property (ramWrite);
  c_micro_read: cover property (rdRamPort && fifoOutValid);

endmodule : bmp_buffer_manager

// ===== bmp_pkg.sv
/*
  Constants of the buffer manager address and count logic: register
  addresses, buffer control bit positions, widths and FIFO shape.
  Assumes a single 100 MHz clock and a byte-wide microcontroller port.
*/
//
// Contract
// - Host pointer is a low byte plus seven high bits, fifteen bits.
// - Host pointer is the start value loaded into the host address counter.
// - Armed host pointer loads when the transfer count is or becomes zero.
// - Loading the host counter clears the host armed status bit.
// - Host count loads into the 12-bit transfer counter with the pointer.
// - Transfer counter limits bytes moved per queued host transfer.
// - Disk pointer, low byte plus seven bits, loads the disk address counter.
// - Armed disk pointer loads when the drive request flag sets; clears armed.
// - Unarmed drive request halts drive transfer until the latch is set.
// - Microcontroller RAM port needs access enable; disk direction steers it.
// - Bus style bit selects XT or AT unless slave; reset leaves it alone.
// - Config read mode floats buffer address outputs; reset clears it.
// - Writing bit 5 clears transfer counter and host FIFO; self-clearing. There is no host FIFO here; only the transfer counter clears.
// - Bit 4 one sets host arm latch; zero ignored; cleared on load/reset.
// - Bit 3 sets host direction: 0 host writes, 1 host reads.
// - Bit 2 sets disk direction: 0 writes RAM, 1 reads RAM.
// - Burst DMA only when burst enable and host DMA select are both one.
// - Bit 0 one sets disk arm latch; zero ignored; cleared after load.
// - Arming disk pointer during microcontroller access flushes the disk FIFO.
// - Status read returns each control bit or latch at the same position.
// - Drive request flag sets on request; held while disk latch was clear.
// - Host DMA select one moves host data by DMA, zero by programmed I/O.
// - Host slave select zero makes host a master; one makes it a slave.

package bmp_pkg;

  // ----------------------------------------------------------------------
  // Register addresses.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_HOST_PTR_LO = 8'h30;
  localparam logic [7:0] ADDR_HOST_PTR_HI = 8'h31;
  localparam logic [7:0] ADDR_HOST_CNT_LO = 8'h32;
  localparam logic [7:0] ADDR_HOST_CNT_HI = 8'h33;
  localparam logic [7:0] ADDR_DISK_PTR_LO = 8'h34;
  localparam logic [7:0] ADDR_DISK_PTR_HI = 8'h35;
  localparam logic [7:0] ADDR_RAM_PORT    = 8'h36;
  localparam logic [7:0] ADDR_BUF_CTRL    = 8'h37;

  // ----------------------------------------------------------------------
  // Buffer control and status bit positions.
  // ----------------------------------------------------------------------
  localparam int BIT_BUS_STYLE = 7;
  localparam int BIT_CFG_READ  = 6;
  localparam int BIT_CLR_CNT   = 5;
  localparam int BIT_HOST_ARM  = 4;
  localparam int BIT_HOST_DIR  = 3;
  localparam int BIT_DISK_DIR  = 2;
  localparam int BIT_BURST     = 1;
  localparam int BIT_DISK_ARM  = 0;

  // ----------------------------------------------------------------------
  // Widths, unmapped read value and FIFO shape.
  // ----------------------------------------------------------------------
  localparam int ADDR_W    = 15;
  localparam int CNT_W     = 12;
  localparam int FIFO_W    = 8;
  localparam int FIFO_D    = 32;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : bmp_pkg

// ===== bmp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns

module bmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  // --------------------------------------------------------------------
  // Full and empty come from the extra pointer bit.
  // --------------------------------------------------------------------
  assign inReady  = (wrPtr_q[PW] == rdPtr_q[PW]) || (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]);
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData  = mem[rdPtr_q[PW-1:0]];
  assign push     = inValid && inReady && !flush;
  assign pop      = outValid && outReady && !flush;

  // Pointer update; a flush empties the FIFO at once.
  always_ff @(posedge clk)
  begin
    if (!resetn || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_q + (PW+1)'(push);
      rdPtr_q <= rdPtr_q + (PW+1)'(pop);
    end
  end

  // Storage write.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q[PW-1:0]] <= inData;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_fifo_level: assert property ((wrPtr_q - rdPtr_q) <= (PW+1)'(DEPTH))
    else $error("FIFO level exceeds its depth.");
  a_fifo_full: assert property (!inReady |-> (wrPtr_q - rdPtr_q) == (PW+1)'(DEPTH))
    else $error("FIFO refuses data while not full.");
  c_fifo_fills: cover property (!inReady);

endmodule : bmp_fifo

// ===== bmp_ram_model.sv
/*
  Behavioural buffer RAM behind the block's RAM port.
  Assumes the block's clock; a write strobe lands, ready was given a cycle before.
*/
`timescale 1ns/1ns

module bmp_ram_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [14:0] ramAddr,
  input  wire logic        ramWrEn,
  input  wire logic [7:0]  ramWrData,
  output logic             ramWrReady,
  input  wire logic        ramRdReq,
  output logic             ramRdValid,
  output logic      [7:0]  ramRdData
);
  logic [7:0] mem [0:32767];

  initial
  begin
    ramRdValid = 1'b0;
    ramRdData  = 8'h00;
  end

  // Stalls writes on command; stale read data is inverted so it never looks held.
  assign ramWrReady = !stall;
  always @(posedge clk)
  begin
    ramRdValid <= ramRdReq;
    ramRdData  <= ramRdReq ? mem[ramAddr] : ~ramRdData;
    if (ramWrEn)
      mem[ramAddr] <= ramWrData;
  end
endmodule : bmp_ram_model

// ===== tb.sv
/*
  Self-checking bench for the buffer manager with a RAM model.
  Assumes register strobes of one cycle, inputs driven at falling edges.
*/
`timescale 1ns/1ns

module tb;
  logic clk = 1'b0, resetn = 1'b0, mcWrite = 1'b0, mcRead = 1'b0, stall = 1'b0;
  logic [7:0] mcAddr = 8'h00, mcWrData = 8'h00, mcRdData_q, ramWrData_q, ramRdData, d;
  logic hostDmaSelect = 1'b0, microRamAccessEnable = 1'b0, hostByteStrobe = 1'b0;
  logic driveBufferRequest = 1'b0, ramWrReady, ramRdValid, ramWrEn_q, ramRdReq_q;
  logic burstDmaActive_q, driveBufferRequestFlag_q, driveHalt_q, bufAddrOe_q;
  logic [14:0] hostAddr_q, diskAddr_q, ramAddr_q;
  logic [11:0] xferCnt_q;
  logic hostSlaveSelect = 1'b0, drqFlagClear = 1'b0, driveByteStrobe = 1'b0, ramPortFull_q;
  logic hostDirection_q, diskDirection_q, clearTransferCounter_q, hostAtMode_q, hostSlaveMode_q, hostDmaMode_q;
  int fail_count = 0, checked = 0, cycles = 0;

  bmp_buffer_manager bmp_buffer_manager_i (.clk, .resetn, .mcAddr, .mcWrite, .mcRead,
    .mcWrData, .mcRdData_q, .ramPortFull_q, .hostDmaSelect, .hostSlaveSelect,
    .microRamAccessEnable, .hostByteStrobe, .driveBufferRequest, .driveByteStrobe,
    .drqFlagClear, .hostAddr_q, .xferCnt_q, .diskAddr_q, .hostDirection_q,
    .diskDirection_q, .clearTransferCounter_q, .hostAtMode_q, .hostSlaveMode_q,
    .hostDmaMode_q, .burstDmaActive_q, .driveBufferRequestFlag_q, .driveHalt_q,
    .bufAddrOe_q, .ramAddr_q, .ramWrEn_q, .ramWrData_q, .ramWrReady, .ramRdReq_q,
    .ramRdValid, .ramRdData);
  bmp_ram_model bmp_ram_model_i (.clk, .stall, .ramAddr(ramAddr_q), .ramWrEn(ramWrEn_q),
    .ramWrData(ramWrData_q), .ramWrReady, .ramRdReq(ramRdReq_q), .ramRdValid, .ramRdData);

  // ----------------------------------------------------------------------
  // Clock, hang guard and shared tasks.
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) {mcAddr, mcWrData, mcWrite} = {a, v, 1'b1};
    @(negedge clk) mcWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk) {mcAddr, mcRead} = {a, 1'b1};
    @(negedge clk) mcRead = 1'b0;
    d = mcRdData_q;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic strobe();
    @(negedge clk) hostByteStrobe = 1'b1;
    @(negedge clk) hostByteStrobe = 1'b0;
  endtask : strobe

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  // Immediate load at zero count, then a queued load behind a running transfer.
  task automatic t_host();
    rd(8'h37); chk(d, 16'h0000);
    chk(bufAddrOe_q, 16'h0001);
    wr(8'h30, 8'hFF); wr(8'h31, 8'hFF); wr(8'h32, 8'h02); wr(8'h33, 8'hF0);
    wr(8'h37, 8'h10); cyc(2);
    chk(hostAddr_q, 16'h7FFF);
    chk(xferCnt_q, 16'h0002);
    wr(8'h30, 8'h00); wr(8'h31, 8'h01); wr(8'h32, 8'h01); wr(8'h33, 8'h00);
    wr(8'h37, 8'h10); rd(8'h37); chk(d, 16'h0010);
    strobe(); chk(hostAddr_q, 16'h0000);
    chk(xferCnt_q, 16'h0001);
    strobe(); cyc(2);
    chk(hostAddr_q, 16'h0100);
    chk(xferCnt_q, 16'h0001);
    rd(8'h37); chk(d, 16'h0000);
    wr(8'h37, 8'h20); chk(clearTransferCounter_q, 16'h0001);
    cyc(2); chk(xferCnt_q, 16'h0000);
    rd(8'h37); chk(d, 16'h0000);
    strobe(); chk(hostAddr_q, 16'h0100);
    $display("host test done");
  endtask : t_host

  // Armed and unarmed drive requests, then burst enable.
  task automatic t_disk();
    wr(8'h34, 8'h34); wr(8'h35, 8'h92); wr(8'h37, 8'h01);
    rd(8'h37); chk(d, 16'h0001);
    driveBufferRequest = 1'b1; cyc(2);
    chk(diskAddr_q, 16'h1234);
    chk(driveBufferRequestFlag_q, 16'h0001);
    rd(8'h37); chk(d, 16'h0000);
    driveBufferRequest = 1'b0; cyc(2); driveBufferRequest = 1'b1; cyc(2);
    chk(driveHalt_q, 16'h0001);
    {driveByteStrobe, drqFlagClear} = 2'b11; cyc(1); {driveByteStrobe, drqFlagClear} = 2'b00;
    chk(diskAddr_q, 16'h1234);
    chk(driveBufferRequestFlag_q, 16'h0001);
    wr(8'h37, 8'h01); cyc(2); chk(driveHalt_q, 16'h0000);
    {driveByteStrobe, drqFlagClear} = 2'b11; cyc(1); {driveByteStrobe, drqFlagClear} = 2'b00;
    chk(diskAddr_q, 16'h1235);
    chk(driveBufferRequestFlag_q, 16'h0000);
    driveBufferRequest = 1'b0; hostDmaSelect = 1'b1;
    wr(8'h37, 8'h0A); cyc(2); chk(burstDmaActive_q, 16'h0001);
    chk(hostDirection_q, 16'h0001);
    chk(hostDmaMode_q, 16'h0001);
    hostDmaSelect = 1'b0; cyc(2); chk(burstDmaActive_q, 16'h0000);
    $display("disk test done");
  endtask : t_disk

  // Microcontroller writes through a stalled RAM, then reads them back.
  task automatic t_micro();
    microRamAccessEnable = 1'b1; stall = 1'b1;
    wr(8'h34, 8'h00); wr(8'h35, 8'h00); wr(8'h37, 8'h01); cyc(2);
    chk(diskAddr_q, 16'h0000);
    wr(8'h36, 8'hA5); wr(8'h36, 8'h5A); cyc(3);
    chk(ramWrEn_q, 16'h0000);
    stall = 1'b0; cyc(6);
    chk(bmp_ram_model_i.mem[0], 16'h00A5);
    chk(bmp_ram_model_i.mem[1], 16'h005A);
    chk(diskAddr_q, 16'h0002);
    wr(8'h37, 8'h05); cyc(110);
    chk(diskDirection_q, 16'h0001);
    chk(ramPortFull_q, 16'h0001);
    rd(8'h36); chk(d, 16'h00A5);
    rd(8'h36); chk(d, 16'h005A);
    microRamAccessEnable = 1'b0; rd(8'h36); chk(d, 16'h0000);
    $display("micro test done");
  endtask : t_micro

  // Config read floats the address pins; reset clears it but keeps bus style.
  task automatic t_cfg();
    wr(8'h37, 8'hC0);
    cyc(2); chk(bufAddrOe_q, 16'h0000);
    rd(8'h37); chk(d, 16'h00C0);
    resetn = 1'b0; cyc(2); resetn = 1'b1;
    chk(bufAddrOe_q, 16'h0001);
    rd(8'h37); chk(d, 16'h0080);
    chk(hostAtMode_q, 16'h0001);
    hostSlaveSelect = 1'b1; cyc(2); chk(hostAtMode_q, 16'h0000);
    chk(hostSlaveMode_q, 16'h0001);
    $display("config test done");
  endtask : t_cfg

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence.
  initial
  begin
    cyc(8);
    resetn = 1'b1;
    t_host();
    t_disk();
    t_micro();
    t_cfg();
    final_report();
  end
endmodule : tb
